//--- verilog/modem_pins_defines.svh
// Offsets, field positions and reset values of the modem pin block
`ifndef MODEM_PINS_DEFINES_SVH
`define MODEM_PINS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DEC_W         5
`define OFF_MCTRL     5'h00
`define OFF_FCTRL     5'h04
`define OFF_MSTAT     5'h08
`define OFF_ISTAT     5'h10
`define OFF_IMASK     5'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_W         8
`define MCR_RTS       1
`define MCR_LOOP      4
`define MCR_AUTO_RTS  5
`define FCR_FIFO_EN   0
`define FCR_DMA_MODE  3
`define MSR_RING_TRAILING_EDGE_FLAG      2
`define MSR_RI        6
`define EV_W          2
`define EV_RING       0
`define EV_RECEIVE_DMA_REQUEST_N      1

// ----------------------------------------------------------------
// Synchroniser lanes and reset values
// ----------------------------------------------------------------
`define SY_W          5
`define SY_RI         0
`define SY_MRST       1
`define SY_NE         2
`define SY_TRIG       3
`define SY_TMO        4
`define SY_RST        5'h01
`define CTL_RST       8'h00
`define EV_RST        2'h0
`define DATA_RST      32'h0000_0000

`endif

//--- verilog/modem_pins_pkg.sv
// Types shared by the modem pin block
package modem_pins_pkg;

  typedef enum logic {RX_IDLE, RX_ACTIVE} rx_dma_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [4:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  q;
    logic [7:0]  modem_control_reg;
    logic [7:0]  fcr;
    logic        ring_trailing_edge_flag;
    logic [1:0]  ev;
    logic [1:0]  mask;
    logic        auto_hold;
    rx_dma_t     rx;
    logic        rts_n;
    logic        receive_dma_request_n_n;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

//--- verilog/modem_pins.sv
// Modem pin status, request-to-send control and receive DMA request
`timescale 1ns/1ps
`include "modem_pins_defines.svh"

module modem_pins
  import modem_pins_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RESET_N,
  // APB slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // Modem and receiver status pins
  input  wire logic              I_RING_INDICATOR_N,
  input  wire logic              I_MASTER_RESET_IN,
  input  wire logic              I_RX_NOT_EMPTY,
  input  wire logic              I_RX_TRIGGER,
  input  wire logic              I_RX_TIMEOUT,
  // Pin outputs
  output logic                   O_REQUEST_TO_SEND_N,
  output logic                   O_RECEIVE_DMA_REQUEST_N,
  output logic                   O_IRQ
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < `DEC_W) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] lo;
    lo = a[4:0];
    return (a[ADDR_W-1:0] >> `DEC_W) == '0 &&
           (hit(lo, `OFF_MCTRL) || hit(lo, `OFF_FCTRL) || hit(lo, `OFF_MSTAT) ||
            hit(lo, `OFF_ISTAT) || hit(lo, `OFF_IMASK));
  endfunction

  state_t   st;
  state_t   n;
  apb_req_t req;
  logic     setup;
  logic     done;
  logic     wr_done;
  logic     msr_rd_done;
  logic     ri_rise;
  logic     mrst;
  logic     fifo_on;
  logic     mode1;
  logic     rx_ne;
  logic     rx_trig;
  logic     rx_tmo;
  logic     ok;

  assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                 paddr: I_PADDR[4:0], pwdata: I_PWDATA};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = st;
    ok = mapped(I_PADDR);
    // Pin inputs: three stages, accept when second and third agree
    n.s1 = {I_RX_TIMEOUT, I_RX_TRIGGER, I_RX_NOT_EMPTY, I_MASTER_RESET_IN,
            I_RING_INDICATOR_N};
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.q  = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
    mrst    = st.q[`SY_MRST];
    rx_ne   = st.q[`SY_NE];
    rx_trig = st.q[`SY_TRIG];
    rx_tmo  = st.q[`SY_TMO];
    ri_rise = n.q[`SY_RI] & ~st.q[`SY_RI];
    fifo_on = st.fcr[`FCR_FIFO_EN];
    mode1   = fifo_on & st.fcr[`FCR_DMA_MODE];

    // APB: setup cycle, then a single access cycle with pready
    setup       = req.psel & ~req.penable;
    done        = req.psel & req.penable & st.pready;
    wr_done     = done & req.pwrite;
    msr_rd_done = done & ~req.pwrite & hit(req.paddr, `OFF_MSTAT) & ok;
    n.pready    = setup;
    n.pslverr   = setup & ~ok;
    n.prdata    = `DATA_RST;
    if (setup && !req.pwrite && ok) begin
      unique case (req.paddr)
        `OFF_MCTRL: n.prdata[7:0] = st.modem_control_reg;
        `OFF_FCTRL: n.prdata[7:0] = st.fcr;
        `OFF_MSTAT: begin
          n.prdata[`MSR_RI]   = ~st.q[`SY_RI];
          n.prdata[`MSR_RING_TRAILING_EDGE_FLAG] = st.ring_trailing_edge_flag;
        end
        `OFF_ISTAT: n.prdata[1:0] = st.ev;
        `OFF_IMASK: n.prdata[1:0] = st.mask;
        default:    n.prdata = `DATA_RST;
      endcase
    end

    // Register writes
    if (wr_done && ok) begin
      if (hit(req.paddr, `OFF_MCTRL)) n.modem_control_reg = req.pwdata[7:0];
      if (hit(req.paddr, `OFF_FCTRL)) n.fcr = req.pwdata[7:0];
      if (hit(req.paddr, `OFF_IMASK)) n.mask = req.pwdata[1:0];
      if (hit(req.paddr, `OFF_ISTAT)) n.ev = st.ev & ~req.pwdata[1:0];
    end

    // Ring trailing edge flag: set wins over read clear
    if (msr_rd_done) n.ring_trailing_edge_flag = 1'b0;
    if (ri_rise) n.ring_trailing_edge_flag = 1'b1;
    if (ri_rise) n.ev[`EV_RING] = 1'b1;

    // Receive DMA request
    unique case (st.rx)
      RX_IDLE: begin
        if (mode1 ? (rx_ne && (rx_trig || rx_tmo)) : rx_ne) n.rx = RX_ACTIVE;
      end
      RX_ACTIVE: begin
        if (!rx_ne) n.rx = RX_IDLE;
      end
    endcase
    if (n.rx == RX_ACTIVE && st.rx == RX_IDLE) n.ev[`EV_RECEIVE_DMA_REQUEST_N] = 1'b1;
    n.receive_dma_request_n_n = ~(n.rx == RX_ACTIVE);

    // Automatic request-to-send: hold off at threshold, release when empty
    if (!(st.modem_control_reg[`MCR_AUTO_RTS] && fifo_on) || !rx_ne) n.auto_hold = 1'b0;
    else if (rx_trig) n.auto_hold = 1'b1;

    // Master reset clears control state
    if (mrst) begin
      n.modem_control_reg       = `CTL_RST;
      n.fcr       = `CTL_RST;
      n.mask      = `EV_RST;
      n.ev        = `EV_RST;
      n.ring_trailing_edge_flag      = 1'b0;
      n.auto_hold = 1'b0;
      n.rx        = RX_IDLE;
      n.receive_dma_request_n_n   = 1'b1;
    end

    n.rts_n = mrst | st.modem_control_reg[`MCR_LOOP] | ~st.modem_control_reg[`MCR_RTS] | n.auto_hold;
    n.irq   = |(n.ev & n.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st           <= '0;
      st.s1        <= `SY_RST;
      st.s2        <= `SY_RST;
      st.s3        <= `SY_RST;
      st.q         <= `SY_RST;
      st.rx        <= RX_IDLE;
      st.rts_n     <= 1'b1;
      st.receive_dma_request_n_n   <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign O_PRDATA                = st.prdata;
  assign O_PREADY                = st.pready;
  assign O_PSLVERR               = st.pslverr;
  assign O_REQUEST_TO_SEND_N     = st.rts_n;
  assign O_RECEIVE_DMA_REQUEST_N = st.receive_dma_request_n_n;
  assign O_IRQ                   = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_msr_setup;
    I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == ADDR_W'(`OFF_MSTAT);
  endsequence

  a_pready_qual: assert property (O_PREADY |-> $past(I_PSEL) && !$past(I_PENABLE))
    else $error("pready without a setup cycle");
  a_ri_status: assert property (s_msr_setup |=> O_PRDATA[`MSR_RI] == !$past(st.q[`SY_RI]))
    else $error("ring state not reflected");
  a_ring_trailing_edge_flag_set: assert property ($rose(st.q[`SY_RI]) |-> st.ring_trailing_edge_flag)
    else $error("ring edge flag not set");
  a_ring_trailing_edge_flag_clear: assert property (msr_rd_done && !ri_rise && !mrst |=> !st.ring_trailing_edge_flag)
    else $error("ring edge flag not cleared by read");
  a_irq_ring: assert property (ri_rise && st.mask[`EV_RING] && !mrst |=> O_IRQ)
    else $error("no interrupt on ring edge");
  a_rts_active: assert property (!mrst && !st.modem_control_reg[`MCR_LOOP] && st.modem_control_reg[`MCR_RTS] &&
                                 !n.auto_hold |=> !O_REQUEST_TO_SEND_N)
    else $error("request-to-send not active");
  a_rts_forced: assert property (mrst || st.modem_control_reg[`MCR_LOOP] || !st.modem_control_reg[`MCR_RTS]
                                 |=> O_REQUEST_TO_SEND_N)
    else $error("request-to-send not forced high");
  a_auto_rts: assert property (st.modem_control_reg[`MCR_AUTO_RTS] && fifo_on && rx_trig && rx_ne
                               |=> O_REQUEST_TO_SEND_N)
    else $error("automatic request-to-send ignored threshold");
  a_dma0_level: assert property (!mode1 && rx_ne && !mrst |=> !O_RECEIVE_DMA_REQUEST_N)
    else $error("mode 0 request missing");
  a_dma_release: assert property (!rx_ne |=> O_RECEIVE_DMA_REQUEST_N)
    else $error("request held while empty");
  a_dma1_assert: assert property (mode1 && rx_ne && (rx_trig || rx_tmo) && !mrst
                                  |=> !O_RECEIVE_DMA_REQUEST_N)
    else $error("mode 1 request missing at threshold");
  a_mrst_clear: assert property (mrst |=> st.modem_control_reg == `CTL_RST && O_REQUEST_TO_SEND_N ##1
                                 O_REQUEST_TO_SEND_N)
    else $error("master reset did not clear control");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------

  sequence s_mcr_write;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == ADDR_W'(`OFF_MCTRL);
  endsequence

  sequence s_fcr_write;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == ADDR_W'(`OFF_FCTRL);
  endsequence

  sequence s_access;
    I_PSEL && I_PENABLE && O_PREADY;
  endsequence

  a_pready_pulse: assert property (s_access |=> !O_PREADY)
    else $error("pready longer than one cycle");

  a_prdata_idle: assert property (!O_PREADY |-> O_PRDATA == `DATA_RST)
    else $error("read data outside the access cycle");

  a_write_no_data: assert property (O_PREADY && $past(I_PWRITE) |-> O_PRDATA == `DATA_RST)
    else $error("read data driven on a write");

  a_slverr_qual: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error response without pready");

  a_slverr_map: assert property (O_PSLVERR |-> !$past(ok))
    else $error("error response on a mapped address");

  a_msr_answer: assert property (s_msr_setup ##1 I_PENABLE |-> O_PREADY && !O_PSLVERR)
    else $error("status read not answered");

  a_mcr_write: assert property (s_mcr_write && !mrst |=> st.modem_control_reg == $past(I_PWDATA[7:0]))
    else $error("modem control write lost");

  a_fcr_write: assert property (s_fcr_write && !mrst |=> st.fcr == $past(I_PWDATA[7:0]))
    else $error("FIFO control write lost");

  // ----------------------------------------------------------------
  // Flag and interrupt checks
  // ----------------------------------------------------------------

  a_ring_trailing_edge_flag_hold: assert property (!msr_rd_done && !ri_rise && !mrst |=> st.ring_trailing_edge_flag == $past(st.ring_trailing_edge_flag))
    else $error("ring edge flag changed by itself");

  a_ring_trailing_edge_flag_mrst: assert property (mrst |=> !st.ring_trailing_edge_flag)
    else $error("ring edge flag survived master reset");

  a_ring_event: assert property (ri_rise && !mrst |=> st.ev[`EV_RING])
    else $error("ring event not recorded");

  a_mrst_quiet: assert property (mrst |=> !O_IRQ && O_RECEIVE_DMA_REQUEST_N)
    else $error("outputs active after master reset");

  a_rx_event: assert property ($fell(O_RECEIVE_DMA_REQUEST_N) |-> st.ev[`EV_RECEIVE_DMA_REQUEST_N])
    else $error("receive request event not recorded");

  a_irq_source: assert property (O_IRQ |-> |(st.ev & st.mask))
    else $error("interrupt without unmasked event");

  // ----------------------------------------------------------------
  // Pin output checks
  // ----------------------------------------------------------------

  a_auto_release: assert property (st.modem_control_reg[`MCR_AUTO_RTS] && !rx_ne && !mrst &&
                                   !st.modem_control_reg[`MCR_LOOP] && st.modem_control_reg[`MCR_RTS] |=> !O_REQUEST_TO_SEND_N)
    else $error("request-to-send not released when empty");

  a_loop_rts: assert property (st.modem_control_reg[`MCR_LOOP] |=> O_REQUEST_TO_SEND_N)
    else $error("request-to-send active in loop mode");

  a_dma1_wait: assert property (mode1 && st.rx == RX_IDLE && !rx_trig && !rx_tmo
                                |=> O_RECEIVE_DMA_REQUEST_N)
    else $error("mode 1 request before threshold");

  a_dma_hold: assert property (st.rx == RX_ACTIVE && rx_ne && !mrst
                               |=> !O_RECEIVE_DMA_REQUEST_N)
    else $error("request dropped while characters held");

  a_mode0_fifo_off: assert property (!fifo_on && rx_ne && !mrst
                                     |=> !O_RECEIVE_DMA_REQUEST_N)
    else $error("character mode request missing");

  // ----------------------------------------------------------------
  // Synchroniser checks
  // ----------------------------------------------------------------

  a_sync_agree: assert property (st.s2 == st.s3 |=> st.q == $past(st.s3))
    else $error("agreed pin level not accepted");

  a_mrst_seen: assert property (st.s2[`SY_MRST] && st.s3[`SY_MRST] |=> mrst)
    else $error("master reset pin not accepted");

endmodule

//--- bench/modem_peer.sv
// Receiver section and DMA controller seen from the pin block
`timescale 1ns/1ps

module modem_peer #(
  parameter int TRIG = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_load,
  input  wire logic       i_burst,
  input  wire logic       i_dma_req_n,
  input  wire logic [4:0] i_fill,
  output logic            o_not_empty,
  output logic            o_trigger
);
  logic [4:0] count_r;
  logic [2:0] gap_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= 5'h00;
      gap_r   <= 3'h0;
    end else if (i_load) begin
      count_r <= i_fill;
    end else if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end else if (!i_dma_req_n && count_r != 5'h00) begin
      // Single transfers spaced out, or a continuous burst
      count_r <= count_r - 5'h01;
      gap_r   <= i_burst ? 3'h0 : 3'h7;
    end
  end

  assign o_not_empty = (count_r != 5'h00);
  assign o_trigger   = (count_r >= 5'(TRIG));
endmodule

//--- bench/test_modem_pins.sv
// Self-checking bench of the modem pin block
`timescale 1ns/1ps
`include "modem_pins_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module test_modem_pins;
  import modem_pins_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ring_n = 1, mrst = 0, ne, trig, tmo = 0;
  logic        rts_n, dma_n, irq, load = 0, burst = 0;
  logic [4:0]  fill = 5'h00;
  logic [31:0] rnd;
  logic [32:0] expq[$];
  int          err_total = 0, n_compared = 0;

  modem_pins DUT (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RING_INDICATOR_N(ring_n),
    .I_MASTER_RESET_IN(mrst), .I_RX_NOT_EMPTY(ne), .I_RX_TRIGGER(trig),
    .I_RX_TIMEOUT(tmo), .O_REQUEST_TO_SEND_N(rts_n), .O_RECEIVE_DMA_REQUEST_N(dma_n),
    .O_IRQ(irq));
  modem_peer peer (.i_clk(clk), .i_reset_n(rst_n), .i_load(load), .i_burst(burst),
    .i_dma_req_n(dma_n), .i_fill(fill), .o_not_empty(ne), .o_trigger(trig));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus master and pin waits
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [4:0] a, input logic [32:0] e);
    int n;
    n = 0;
    if (!w) expq.push_back(e);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {3'h0, a}; pwdata <= e[31:0];
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      `CHK(pready, 1'b1)
      report_and_stop();
    end
    psel <= 0; penable <= 0;
  endtask

  task automatic wait_pin(input int which, input logic v);
    logic s;
    int   n;
    for (n = 0; n < 80; n++) begin
      @(posedge clk);
      s = (which == 0) ? rts_n : (which == 1) ? dma_n : irq;
      if (s === v) break;
    end
    `CHK(s, v)
  endtask

  task automatic give(input logic [4:0] f);
    @(posedge clk);
    load <= 1; fill <= f;
    @(posedge clk);
    load <= 0;
  endtask

  always @(posedge clk) begin
    if (pready === 1'b1 && !pwrite) `CHK({pslverr, prdata}, expq.pop_front())
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'he4b6));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    `CHK({rts_n, dma_n, irq}, 3'b110)
    rnd = $urandom;
    apb(1, `OFF_IMASK, {1'b0, rnd});
    apb(0, `OFF_IMASK, {1'b0, rnd & 32'h3});
    apb(0, 5'h0c, 33'h1_0000_0000);
    apb(1, `OFF_IMASK, 33'h1);
    ring_n <= 0;
    repeat (6) @(posedge clk);
    apb(0, `OFF_MSTAT, 33'h40);
    ring_n <= 1;
    wait_pin(2, 1'b1);
    apb(0, `OFF_MSTAT, 33'h04);
    apb(0, `OFF_MSTAT, 33'h00);
    apb(0, `OFF_ISTAT, 33'h01);
    apb(1, `OFF_ISTAT, 33'h01);
    wait_pin(2, 1'b0);
    apb(1, `OFF_MCTRL, 33'h02);
    wait_pin(0, 1'b0);
    apb(1, `OFF_MCTRL, 33'h12);
    wait_pin(0, 1'b1);
    apb(1, `OFF_MCTRL, 33'h02);
    wait_pin(0, 1'b0);
    apb(1, `OFF_MCTRL, 33'h00);
    wait_pin(0, 1'b1);
    give(5'h03);
    wait_pin(1, 1'b0);
    wait_pin(1, 1'b1);
    apb(1, `OFF_FCTRL, 33'h08);
    give(5'h01);
    wait_pin(1, 1'b0);
    wait_pin(1, 1'b1);
    apb(1, `OFF_FCTRL, 33'h09);
    burst <= 1;
    give(5'h02);
    repeat (10) @(posedge clk);
    `CHK(dma_n, 1'b1)
    tmo <= 1;
    wait_pin(1, 1'b0);
    tmo <= 0;
    wait_pin(1, 1'b1);
    burst <= 0;
    apb(1, `OFF_FCTRL, 33'h01);
    apb(1, `OFF_MCTRL, 33'h22);
    wait_pin(0, 1'b0);
    give(5'h05);
    wait_pin(0, 1'b1);
    wait_pin(0, 1'b0);
    mrst <= 1;
    wait_pin(0, 1'b1);
    apb(0, `OFF_MCTRL, 33'h00);
    mrst <= 0;
    repeat (8) @(posedge clk);
    `CHK(rts_n, 1'b1)
    report_and_stop();
  end
endmodule
